/* tdq_consts.svh */
// constants for the transmit descriptor queue threshold block
`ifndef TDQ_CONSTS_SVH
`define TDQ_CONSTS_SVH
`define TDQ_CNT_W 10
`define TDQ_AW 8
`define TDQ_OFF_CTRL 8'h00
`define TDQ_OFF_ISTS 8'h04
`define TDQ_OFF_ICLR 8'h08
`define TDQ_OFF_IEN 8'h0c
`define TDQ_OFF_CNT 8'h10
`define TDQ_CTRL_WMASK 32'hff3f_3f3f
`define TDQ_CTRL_RST 32'h0000_0000
`define TDQ_THR_LSB 0
`define TDQ_THR_STEP 8
`define TDQ_THR_W 6
`define TDQ_THRESHOLD_GRANULARITY_BIT 24
`define TDQ_LOW_MSB 31
`define TDQ_LOW_LSB 25
`define TDQ_LOW_SHIFT 3
`define TDQ_LINE_SHIFT 2
`define TDQ_IX_PTH 0
`define TDQ_IX_HTH 1
`define TDQ_IX_WTH 2
`define TDQ_EV_LOW 0
`define TDQ_EV_WB 1
`define TDQ_NEV 2
`define TDQ_RESP_OKAY 2'h0
`define TDQ_RESP_DECERR 2'h3
`endif

/* tdq_pkg.sv */
// types shared by the descriptor queue threshold block
`default_nettype none
`include "tdq_consts.svh"
package tdq_pkg;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [`TDQ_NEV-1:0] ien;
        logic [`TDQ_NEV-1:0] ists;
        logic [`TDQ_CNT_W-1:0] cache_cnt;
        logic [`TDQ_CNT_W-1:0] wb_cnt;
        logic [`TDQ_CNT_W-1:0] wb_len;
        logic accum;
        logic fetch_req;
        logic wb_req;
        logic irq;
        logic awready;
        logic wready;
        logic aw_hold;
        logic w_hold;
        logic [`TDQ_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tdq_state_type;
endpackage
`default_nettype wire

/* tdq_thr_if.sv */
// control word in, thresholds in descriptor units out
`timescale 1ns/1ps
`default_nettype none
`include "tdq_consts.svh"
interface tdq_thr_if;
    logic [31:0] ctrl;
    logic [2:0][`TDQ_CNT_W-1:0] thr;
    modport owner (output ctrl, input thr);
    modport scaler (input ctrl, output thr);
endinterface
`default_nettype wire

/* tdq_scale.sv */
// converts the three queue thresholds to descriptor units
`timescale 1ns/1ps
`default_nettype none
`include "tdq_consts.svh"
module tdq_scale (
    tdq_thr_if.scaler t
);
    // one cache line holds several 16-byte descriptors
    for (genvar g = 0; g < 3; g++) begin : g_thr
        logic [`TDQ_THR_W-1:0] raw;
        assign raw = t.ctrl[`TDQ_THR_LSB + g*`TDQ_THR_STEP +: `TDQ_THR_W];
        assign t.thr[g] = t.ctrl[`TDQ_THRESHOLD_GRANULARITY_BIT] ? // R2
            `TDQ_CNT_W'(raw) : (`TDQ_CNT_W'(raw) << `TDQ_LINE_SHIFT);
    end
endmodule // tdq_scale
`default_nettype wire

/* tdq_top.sv */
// descriptor prefetch, write-back and low-water logic with axi4-lite regs
`timescale 1ns/1ps
`default_nettype none
`include "tdq_consts.svh"
// Functional notes
// (R1) fetch only with enough host descriptors, no higher dma, cache below prefetch
// (R2) granularity bit selects cache-line or descriptor units for thresholds
// (R3) without flush, write back only when more than write-back threshold wait
// (R4) write-back threshold zero writes each descriptor back at once
// (R5) only count after a report-status descriptor starts accumulation
// (R6) a burst may carry descriptors without report status
// (R7) low threshold field sets the descriptor-low interrupt level
// (R8) interrupt when count falls from eight times field plus one
// (R9) field zero raises the interrupt only when the cache empties
// (R10) reserved control bits read zero; software writes zero
// (R11) prefetch considered only while cache count below prefetch threshold
// (R12) software advances ring tail; device processes head to tail; this block keeps no ring head or tail pointers
module tdq_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [`TDQ_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`TDQ_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [15:0] host_desc_avail_i,
    input wire logic higher_prio_pending_i,
    input wire logic fetch_ack_i,
    input wire logic [`TDQ_CNT_W-1:0] fetch_cnt_i,
    input wire logic desc_done_i,
    input wire logic report_status_flag_i,
    input wire logic flush_i,
    input wire logic wb_ack_i,
    output logic fetch_req_o,
    output logic wb_req_o,
    output logic [`TDQ_CNT_W-1:0] wb_len_o,
    output logic irq_o
);
    tdq_pkg::tdq_state_type r;
    tdq_pkg::tdq_state_type n;
    tdq_thr_if thr_if ();
    logic [`TDQ_CNT_W-1:0] pth_s;
    logic [`TDQ_CNT_W-1:0] hth_s;
    logic [`TDQ_CNT_W-1:0] wth_s;
    logic [`TDQ_CNT_W-1:0] low_thr;
    logic fetch_ok;
    logic wb_want;

    // thresholds scaled by granularity in the leaf module
    assign thr_if.ctrl = r.ctrl;
    tdq_scale u_scale (
        .t(thr_if.scaler)
    );
    assign pth_s = thr_if.thr[`TDQ_IX_PTH];
    assign hth_s = thr_if.thr[`TDQ_IX_HTH];
    assign wth_s = thr_if.thr[`TDQ_IX_WTH];
    // low threshold is in groups of eight descriptors
    assign low_thr = `TDQ_CNT_W'(r.ctrl[`TDQ_LOW_MSB:`TDQ_LOW_LSB])
        << `TDQ_LOW_SHIFT; // R7 R8

    // prefetch condition: all three must hold together
    assign fetch_ok = (16'(host_desc_avail_i) >= 16'(hth_s)) // R1
        && !higher_prio_pending_i // R1
        && (r.cache_cnt < pth_s); // R11
    // zero threshold means no bursting, else strictly more than threshold
    assign wb_want = (flush_i && (r.wb_cnt != '0))
        || ((wth_s == '0) ? (r.wb_cnt != '0) // R4
        : (r.wb_cnt > wth_s)); // R3

    // next-state logic for bus, counters and events
    always_comb begin
        logic [`TDQ_CNT_W-1:0] cnt_n;
        logic [`TDQ_NEV-1:0] ev;
        logic [31:0] val;
        logic [`TDQ_AW-1:0] ra;
        cnt_n = '0;
        ev = '0;
        val = '0;
        ra = s_axi_araddr_i;
        n = r;

        // on-chip cache occupancy
        cnt_n = r.cache_cnt;
        if (fetch_ack_i) begin
            cnt_n = cnt_n + fetch_cnt_i;
        end
        if (desc_done_i && (cnt_n != '0)) begin
            cnt_n = cnt_n - `TDQ_CNT_W'(1);
        end
        n.cache_cnt = cnt_n;
        // exact crossing; with field zero that is the cache going empty
        ev[`TDQ_EV_LOW] = (r.cache_cnt == low_thr + `TDQ_CNT_W'(1))
            && (cnt_n == low_thr); // R8 R9

        // request dropped on the ack cycle; otherwise recomputed each cycle from live conditions
        n.fetch_req = fetch_ok && !fetch_ack_i; // R1

        // write-back count; ack subtracts only what was sent
        if (wb_ack_i) begin
            n.wb_cnt = r.wb_cnt - r.wb_len;
            n.wb_req = 1'b0;
            ev[`TDQ_EV_WB] = 1'b1;
            if (n.wb_cnt == '0) begin
                n.accum = 1'b0;
            end
        end else if (!r.wb_req && wb_want) begin
            n.wb_req = 1'b1;
            n.wb_len = r.wb_cnt; // R6
        end
        // accumulation starts at the first report-status descriptor
        if (desc_done_i && (r.accum || report_status_flag_i)) begin // R5
            n.wb_cnt = n.wb_cnt + `TDQ_CNT_W'(1); // R6
            n.accum = 1'b1;
        end

        // bus write: address and data taken in either order
        if (s_axi_awvalid_i && r.awready) begin
            n.aw_hold = 1'b1;
            n.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && r.wready) begin
            n.w_hold = 1'b1;
            n.wdata = s_axi_wdata_i;
            n.wstrb = s_axi_wstrb_i;
        end
        if (r.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_hold && r.w_hold && !r.bvalid) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `TDQ_RESP_OKAY;
            val = r.ctrl;
            for (int i = 0; i < 4; i++) begin
                if (r.wstrb[i]) begin
                    val[8*i +: 8] = r.wdata[8*i +: 8];
                end
            end
            case (r.awaddr)
                `TDQ_OFF_CTRL: n.ctrl = val & `TDQ_CTRL_WMASK; // R10
                `TDQ_OFF_IEN: begin
                    if (r.wstrb[0]) begin
                        n.ien = r.wdata[`TDQ_NEV-1:0];
                    end
                end
                `TDQ_OFF_ICLR: begin
                    if (r.wstrb[0]) begin
                        n.ists = r.ists & ~r.wdata[`TDQ_NEV-1:0];
                    end
                end
                `TDQ_OFF_ISTS, `TDQ_OFF_CNT: begin
                end
                default: n.bresp = `TDQ_RESP_DECERR;
            endcase
        end
        // ready only while the holding slot is free
        n.awready = !n.aw_hold;
        n.wready = !n.w_hold;

        // sticky events; a set in the clear cycle wins
        n.ists = n.ists | ev; // R7
        n.irq = |(n.ists & n.ien);

        // bus read: one outstanding, data registered
        if (r.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `TDQ_RESP_OKAY;
            case (ra)
                `TDQ_OFF_CTRL: n.rdata = r.ctrl; // R10
                `TDQ_OFF_ISTS: n.rdata = 32'(r.ists);
                `TDQ_OFF_IEN: n.rdata = 32'(r.ien);
                `TDQ_OFF_ICLR: n.rdata = 32'h0000_0000;
                `TDQ_OFF_CNT: n.rdata = {6'h00, r.wb_cnt,
                    6'h00, r.cache_cnt};
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = `TDQ_RESP_DECERR;
                end
            endcase
        end
        n.arready = !n.rvalid;
    end

    // single state register, cleared to constants
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.ctrl <= `TDQ_CTRL_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready_o = r.awready;
    assign s_axi_wready_o = r.wready;
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_bresp_o = r.bresp;
    assign s_axi_arready_o = r.arready;
    assign s_axi_rvalid_o = r.rvalid;
    assign s_axi_rresp_o = r.rresp;
    assign s_axi_rdata_o = r.rdata;
    assign fetch_req_o = r.fetch_req;
    assign wb_req_o = r.wb_req;
    assign wb_len_o = r.wb_len;
    assign irq_o = r.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_fetch_prio;
        $past(higher_prio_pending_i) |-> !fetch_req_o;
    endproperty
    a_fetch_prio: assert property (p_fetch_prio) // R1
        else $error("fetch raised while higher dma pending");

    property p_fetch_host;
        $past(16'(host_desc_avail_i) < 16'(hth_s)) |-> !fetch_req_o;
    endproperty
    a_fetch_host: assert property (p_fetch_host) // R1
        else $error("fetch raised with too few host descriptors");

    property p_fetch_pth;
        $past(r.cache_cnt >= pth_s) |-> !fetch_req_o;
    endproperty
    a_fetch_pth: assert property (p_fetch_pth) // R11
        else $error("fetch raised with cache at prefetch level");

    // all three conditions together must raise the request
    property p_fetch_all;
        $past((16'(host_desc_avail_i) >= 16'(hth_s))
            && !higher_prio_pending_i && (r.cache_cnt < pth_s)
            && !fetch_ack_i) |-> fetch_req_o;
    endproperty
    a_fetch_all: assert property (p_fetch_all) // R1
        else $error("fetch not raised with all conditions met");

    property p_threshold_granularity;
        r.ctrl[`TDQ_THRESHOLD_GRANULARITY_BIT] |-> (pth_s ==
            `TDQ_CNT_W'(r.ctrl[`TDQ_THR_LSB +: `TDQ_THR_W]));
    endproperty
    a_threshold_granularity: assert property (p_threshold_granularity) // R2
        else $error("descriptor granularity not applied");

    property p_wb_thr;
        $rose(wb_req_o) |-> $past(flush_i) || $past(r.wb_cnt > wth_s)
            || $past(wth_s == '0);
    endproperty
    a_wb_thr: assert property (p_wb_thr) // R3
        else $error("write-back below threshold without flush");

    property p_wb_zero;
        (wth_s == '0 && r.wb_cnt != '0 && !r.wb_req && !wb_ack_i)
            |=> wb_req_o ##1 wb_req_o || wb_ack_i || $past(wb_ack_i);
    endproperty
    a_wb_zero: assert property (p_wb_zero) // R4
        else $error("zero threshold did not write back at once");

    property p_rs_start;
        (!r.accum && desc_done_i && !report_status_flag_i && !wb_ack_i)
            |=> (r.wb_cnt == $past(r.wb_cnt));
    endproperty
    a_rs_start: assert property (p_rs_start) // R5
        else $error("counted descriptor before report status");

    property p_low_ev;
        ($past(r.cache_cnt) == $past(low_thr) + `TDQ_CNT_W'(1))
            && (r.cache_cnt == $past(low_thr)) |-> r.ists[`TDQ_EV_LOW];
    endproperty
    a_low_ev: assert property (p_low_ev) // R8
        else $error("descriptor-low cause missed");

    // the cause may only appear on the exact downward crossing
    property p_low_exact;
        $rose(r.ists[`TDQ_EV_LOW]) |->
            ($past(r.cache_cnt) == $past(low_thr) + `TDQ_CNT_W'(1))
            && (r.cache_cnt == $past(low_thr));
    endproperty
    a_low_exact: assert property (p_low_exact) // R8
        else $error("descriptor-low cause set off the crossing");

    property p_low_zero;
        $rose(r.ists[`TDQ_EV_LOW]) && ($past(low_thr) == '0)
            |-> (r.cache_cnt == '0);
    endproperty
    a_low_zero: assert property (p_low_zero) // R9
        else $error("zero low threshold raised cause with cache not empty");

    property p_resv;
        (r.ctrl & ~`TDQ_CTRL_WMASK) == 32'h0000_0000;
    endproperty
    a_resv: assert property (p_resv) // R10
        else $error("reserved control bits not zero");

    // level output tracks enabled status; enable may drop any cycle
    property p_irq;
        irq_o == |(r.ists & r.ien);
    endproperty
    a_irq: assert property (p_irq) // R7
        else $error("enabled low cause did not raise interrupt");
endmodule // tdq_top
`default_nettype wire

/* tdq_host_model.sv */
// host memory stand-in answering fetch and write-back requests
`timescale 1ns/1ps
`default_nettype none
module tdq_host_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic fetch_req_i,
    input wire logic wb_req_i,
    input wire logic slow_i,
    input wire logic [9:0] cnt_i,
    output logic fetch_ack_o,
    output logic wb_ack_o,
    output logic [9:0] fetch_cnt_o
);
    logic [3:0] fwait, wwait, lim;
    // slow mode stalls each answer, as a busy memory would
    assign lim = slow_i ? 4'h5 : 4'h0;
    // count only means something with the ack; junk otherwise
    assign fetch_cnt_o = fetch_ack_o ? cnt_i : ~cnt_i;
    // one ack pulse per request, never two in a row
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {fetch_ack_o, wb_ack_o, fwait, wwait} <= 10'h0;
        end else begin
            fetch_ack_o <= fetch_req_i && !fetch_ack_o && fwait >= lim;
            fwait <= (fetch_req_i && !fetch_ack_o) ? fwait + 4'h1 : 4'h0;
            wb_ack_o <= wb_req_i && !wb_ack_o && wwait >= lim;
            wwait <= (wb_req_i && !wb_ack_o) ? wwait + 4'h1 : 4'h0;
        end
    end
endmodule // tdq_host_model
`default_nettype wire

/* test_tx_descriptor_queue_thresholds.sv */
// self-checking bench for the descriptor queue threshold block
`timescale 1ns/1ps
`default_nettype none
`include "tdq_consts.svh"
module test_tx_descriptor_queue_thresholds;
    logic clk_i = 1'h0;
    logic arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, slow;
    logic [`TDQ_AW-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [15:0] host_desc_avail_i;
    logic higher_prio_pending_i, fetch_ack_i, desc_done_i, flush_i;
    logic report_status_flag_i, wb_ack_i, fetch_req_o, wb_req_o, irq_o;
    logic [`TDQ_CNT_W-1:0] fetch_cnt_i, wb_len_o, cnt;
    int failures = 0;
    int n_compared = 0;
    int k;

    tdq_top uut (.clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .host_desc_avail_i,
        .higher_prio_pending_i, .fetch_ack_i, .fetch_cnt_i, .desc_done_i,
        .report_status_flag_i, .flush_i, .wb_ack_i, .fetch_req_o, .wb_req_o,
        .wb_len_o, .irq_o);
    tdq_host_model host (.clk_i, .arst_n_i, .fetch_req_i(fetch_req_o),
        .wb_req_i(wb_req_o), .slow_i(slow), .cnt_i(cnt),
        .fetch_ack_o(fetch_ack_i), .wb_ack_o(wb_ack_i),
        .fetch_cnt_o(fetch_cnt_i));

    // 100 MHz
    always #5 clk_i = ~clk_i;

    task complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task hang;
        $display("BAD handshake expected 1 seen timeout");
        failures++;
        complete_run;
    endtask
    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= 4'hf;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
            if (s_axi_bvalid_o) begin
                rsp = s_axi_bresp_o;
                s_axi_bready_i <= 1'h0;
                break;
            end
        end
        if (k == 50) hang;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
            if (s_axi_rvalid_o) begin
                rd = s_axi_rdata_o;
                rsp = s_axi_rresp_o;
                s_axi_rready_i <= 1'h0;
                break;
            end
        end
        if (k == 50) hang;
    endtask
    // 0 fetch ack, 1 write-back request, 2 interrupt, 3 write-back ack
    task wait_for(input int sel);
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if ((sel == 0 && fetch_ack_i) || (sel == 1 && wb_req_o) ||
                (sel == 2 && irq_o) || (sel == 3 && wb_ack_i)) break;
        end
        if (k == 50) hang;
    endtask
    // one processed descriptor; flag is junk outside the pulse
    task desc(input logic rs);
        @(posedge clk_i);
        desc_done_i <= 1'h1;
        report_status_flag_i <= rs;
        @(posedge clk_i);
        desc_done_i <= 1'h0;
        report_status_flag_i <= ~rs;
    endtask
    task sc_regs;
        rd_reg(`TDQ_OFF_CTRL);
        chk("ctrl reset", 32'h0, rd);
        wr(`TDQ_OFF_CTRL, 32'hffff_ffff);
        rd_reg(`TDQ_OFF_CTRL);
        chk("ctrl reserved", 32'hff3f_3f3f, rd);
        wr(8'h40, 32'h1);
        chk("unmapped wr", 32'h3, 32'(rsp));
        rd_reg(8'h40);
        chk("unmapped rd", 32'h3, 32'(rsp));
    endtask
    task sc_fetch;
        cnt <= 10'h4;
        host_desc_avail_i <= 16'h1;
        wr(`TDQ_OFF_CTRL, 32'h0100_0204);
        repeat (5) @(posedge clk_i);
        chk("fetch few host", 32'h0, 32'(fetch_req_o));
        host_desc_avail_i <= 16'h2;
        higher_prio_pending_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        chk("fetch prio busy", 32'h0, 32'(fetch_req_o));
        higher_prio_pending_i <= 1'h0;
        wait_for(0);
        repeat (5) @(posedge clk_i);
        chk("fetch at pth", 32'h0, 32'(fetch_req_o));
        rd_reg(`TDQ_OFF_CNT);
        chk("cache count", 32'h4, rd);
        wr(`TDQ_OFF_CTRL, 32'h0000_0202);
        repeat (5) @(posedge clk_i);
        chk("line units", 32'h0, 32'(fetch_req_o));
        slow <= 1'h0;
        host_desc_avail_i <= 16'h8;
        wait_for(0);
        host_desc_avail_i <= 16'h0;
        rd_reg(`TDQ_OFF_CNT);
        chk("line fetch", 32'h8, rd);
    endtask
    task sc_low;
        cnt <= 10'h1;
        host_desc_avail_i <= 16'h1;
        wr(`TDQ_OFF_CTRL, 32'h0300_0109);
        wait_for(0);
        host_desc_avail_i <= 16'h0;
        wr(`TDQ_OFF_IEN, 32'h1);
        rd_reg(`TDQ_OFF_ISTS);
        chk("low on rise", 32'h0, rd);
        desc(1'h0);
        wait_for(2);
        rd_reg(`TDQ_OFF_ISTS);
        chk("low cause", 32'h1, rd);
        wr(`TDQ_OFF_ISTS, 32'h0);
        chk("status wr resp", 32'h0, 32'(rsp));
        rd_reg(`TDQ_OFF_ISTS);
        chk("status read only", 32'h1, rd);
        rd_reg(`TDQ_OFF_ICLR);
        chk("clear reads zero", 32'h0, rd);
        wr(`TDQ_OFF_ICLR, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0, 32'(irq_o));
        wr(`TDQ_OFF_CTRL, 32'h0100_0000);
        for (int i = 0; i < 7; i++) desc(1'h0);
        repeat (3) @(posedge clk_i);
        chk("low zero early", 32'h0, 32'(irq_o));
        desc(1'h0);
        wait_for(2);
        wr(`TDQ_OFF_IEN, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq masked", 32'h0, 32'(irq_o));
        wr(`TDQ_OFF_ICLR, 32'h1);
    endtask
    task sc_wb;
        slow <= 1'h1;
        wr(`TDQ_OFF_CTRL, 32'h0102_0000);
        desc(1'h0);
        desc(1'h0);
        rd_reg(`TDQ_OFF_CNT);
        chk("no rs no count", 32'h0, rd);
        desc(1'h1);
        desc(1'h0);
        rd_reg(`TDQ_OFF_CNT);
        chk("accumulate", 32'h0002_0000, rd);
        chk("wb at thresh", 32'h0, 32'(wb_req_o));
        desc(1'h0);
        wait_for(1);
        chk("wb burst len", 32'h3, 32'(wb_len_o));
        wait_for(3);
        rd_reg(`TDQ_OFF_ISTS);
        chk("wb done cause", 32'h2, rd);
        desc(1'h1);
        @(posedge clk_i);
        flush_i <= 1'h1;
        @(posedge clk_i);
        flush_i <= 1'h0;
        wait_for(1);
        chk("flush len", 32'h1, 32'(wb_len_o));
        wait_for(3);
        wr(`TDQ_OFF_CTRL, 32'h0100_0000);
        desc(1'h1);
        wait_for(1);
        chk("wb at once", 32'h1, 32'(wb_len_o));
    endtask
    initial begin
        {arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
        {s_axi_arvalid_i, s_axi_rready_i, higher_prio_pending_i} = 3'h0;
        {desc_done_i, report_status_flag_i, flush_i} = 3'h0;
        {s_axi_awaddr_i, s_axi_araddr_i} = 16'h0;
        {s_axi_wdata_i, s_axi_wstrb_i} = 36'h0;
        host_desc_avail_i = 16'h0;
        cnt = 10'h0;
        slow = 1'h1;
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'h1;
        sc_regs;
        sc_fetch;
        sc_low;
        sc_wb;
        complete_run;
    end
endmodule // test_tx_descriptor_queue_thresholds
`default_nettype wire
